// ==== logic/swpc_config_top.sv ====
/*
  Configuration register bank of one switch port: identifiers, command,
  power budgeting, access control and latency reporting registers.
  Assumes configuration requests, override strobes and request events
  all come from logic on CLK; none are pins, so none are synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [RQ1] io enable clear: ignore primary io requests; set: respond; resets 0
// [RQ2] memory enable clear: ignore primary memory requests; set: respond
// [RQ3] bus master clear: no upstream requests; downstream ones become ur
// [RQ4] rejected non-posted request gets an unsupported-request completion
// [RQ5] bus master set: forward memory and io requests upstream
// [RQ6] bits 3,4,5,7,9 read zero and ignore writes
// [RQ7] parity response enable gates parity error action; resets 0
// [RQ8] serr enable gates fatal and non-fatal error reporting; resets 0
// [RQ9] interrupt disable stops own intx messages, not forwarded ones
// [RQ10] vendor and device ids read-only; overridable by smbus or eeprom
// [RQ11] access control cap and control at 224h, egress vector after it
// [RQ12] reserved command bits 15:11 read zero, writes kept, not acted on
module swpc_config_top (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic CFG_REQ,
  input wire logic CFG_WR,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_ACK,
  input wire logic SMB_ID_WE,
  input wire logic SMB_ID_SEL,
  input wire logic [15:0] SMB_ID_DATA,
  input wire logic EE_ID_WE,
  input wire logic EE_ID_SEL,
  input wire logic [15:0] EE_ID_DATA,
  input wire logic PRI_REQ_VALID,
  input wire logic PRI_REQ_IO,
  output logic PRI_REQ_TAKE,
  output logic PRI_REQ_IGNORE,
  input wire logic DN_REQ_VALID,
  input wire logic DN_REQ_NP,
  output logic DN_REQ_FWD,
  output logic DN_REQ_UR,
  output logic DN_UR_CPL,
  input wire logic OWN_REQ_VALID,
  output logic OWN_REQ_GO,
  input wire logic PERR_DET,
  output logic PERR_ACT,
  input wire logic ERR_DET,
  output logic ERR_MSG,
  input wire logic OWN_INTX,
  output logic OWN_INTX_MSG,
  input wire logic DN_INTX,
  output logic DN_INTX_FWD,
  output logic [15:0] ACS_CTRL,
  output logic [7:0] EGRESS_BLOCK,
  output logic [31:0] LTR_SNOOP
);

  // ****************************************
  // state and sub-blocks
  // ****************************************

  swpc_pkg::swpc_top_st_t st_ff;
  swpc_pkg::swpc_top_st_t nxt_st;
  swpc_pkg::swpc_flt_st_t flt_q;
  swpc_ctl_if ctl ();

  // identifiers live in their own block so override ports stay local
  swpc_id_loader u_idl (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .smb_we(SMB_ID_WE),
    .smb_sel(SMB_ID_SEL),
    .smb_data(SMB_ID_DATA),
    .ee_we(EE_ID_WE),
    .ee_sel(EE_ID_SEL),
    .ee_data(EE_ID_DATA),
    .ctl(ctl)
  );

  // request gating against the command bits
  swpc_req_filter u_flt (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .ctl(ctl),
    .pri_valid(PRI_REQ_VALID),
    .pri_io(PRI_REQ_IO),
    .dn_valid(DN_REQ_VALID),
    .dn_np(DN_REQ_NP),
    .own_valid(OWN_REQ_VALID),
    .perr_det(PERR_DET),
    .err_det(ERR_DET),
    .own_intx(OWN_INTX),
    .dn_intx(DN_INTX),
    .q(flt_q)
  );

  // ****************************************
  // helpers
  // ****************************************

  // merge write data into an old word under byte enables and a mask
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] bmask;
    bmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    be_merge = (old & ~bmask) | (wdat & bmask);
  endfunction : be_merge

  // header dword of an extended capability
  function automatic logic [31:0] ext_hdr(
    input logic [11:0] nxt,
    input logic [15:0] id
  );
    ext_hdr = {nxt, swpc_pkg::CAP_VER, id};
  endfunction : ext_hdr

  // ****************************************
  // command word view
  // ****************************************

  logic [15:0] cmd_rd;
  logic [31:0] cmd_wr;
  logic [31:0] cmd_merged;

  // legacy bits 3,4,5,7,9 are absent from the view and read as zero
  always_comb
  begin
    cmd_rd = '0; // RQ6
    cmd_rd[swpc_pkg::CMD_IO] = st_ff.io_en;
    cmd_rd[swpc_pkg::CMD_MEM] = st_ff.mem_en;
    cmd_rd[swpc_pkg::CMD_BM] = st_ff.bm_en;
    cmd_rd[swpc_pkg::CMD_PERR] = st_ff.perr_en;
    cmd_rd[swpc_pkg::CMD_SERR] = st_ff.serr_en;
    cmd_rd[swpc_pkg::CMD_INTD] = st_ff.intx_dis;
    // reserved bits are held but never shown or used
    cmd_wr = '0;
    cmd_wr[15:0] = cmd_rd;
    cmd_wr[swpc_pkg::CMD_RSVD_MSB:swpc_pkg::CMD_RSVD_LSB] = st_ff.rsvd;
    cmd_merged = be_merge(cmd_wr, CFG_WDATA, CFG_BE, 32'h0000_FFFF);
  end

  // ****************************************
  // power budget data lookup
  // ****************************************

  logic [31:0] pb_data;

  // selects past the table read as zero, which ends the walk for software
  always_comb
  begin
    if (st_ff.pb_sel < 8'(swpc_pkg::PB_ENTRIES))
      pb_data = swpc_pkg::PB_TABLE[st_ff.pb_sel[1:0]];
    else
      pb_data = '0;
  end

  // ****************************************
  // read decode
  // ****************************************

  logic [31:0] rd_word;
  logic [31:0] acs_word;

  // unmapped offsets read zero, as unimplemented config space must
  always_comb
  begin
    acs_word = {st_ff.acs_ctl, swpc_pkg::ACS_CAP_VAL}; // RQ11
    case (CFG_ADDR & 12'hFFC)
      swpc_pkg::OFS_ID:
        rd_word = {ctl.device_identifier, ctl.vendor_identifier}; // RQ10
      swpc_pkg::OFS_CMD:
        rd_word = {16'h0000, cmd_rd}; // RQ6 RQ12
      swpc_pkg::OFS_PB_SEL:
        rd_word = {24'h00_0000, st_ff.pb_sel};
      swpc_pkg::OFS_PB_DATA:
        rd_word = pb_data;
      swpc_pkg::OFS_PB_CAP:
        rd_word = {24'h00_0000, swpc_pkg::PB_CAP_VAL};
      swpc_pkg::OFS_ACS_HDR:
        rd_word = ext_hdr(swpc_pkg::NEXT_NONE, swpc_pkg::ACS_CAP_ID);
      swpc_pkg::OFS_ACS_CC:
        rd_word = acs_word; // RQ11
      swpc_pkg::OFS_EGRESS:
        rd_word = {24'h00_0000, st_ff.egress}; // RQ11
      swpc_pkg::OFS_LTR_HDR:
        rd_word = ext_hdr(swpc_pkg::NEXT_NONE, swpc_pkg::LTR_CAP_ID);
      swpc_pkg::OFS_LTR_SNOOP:
        rd_word = st_ff.ltr;
      default:
        rd_word = '0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************

  logic wr_hit;
  logic [31:0] acs_merged;
  logic [31:0] egr_merged;
  logic [31:0] ltr_merged;
  logic [31:0] sel_merged;

  // writes to read-only words are accepted and dropped silently
  always_comb
  begin
    nxt_st = st_ff;
    wr_hit = CFG_REQ && CFG_WR;
    acs_merged = be_merge(acs_word, CFG_WDATA, CFG_BE,
      {swpc_pkg::ACS_CTL_MASK, 16'h0000});
    egr_merged = be_merge({24'h00_0000, st_ff.egress}, CFG_WDATA,
      CFG_BE, 32'h0000_00FF);
    ltr_merged = be_merge(st_ff.ltr, CFG_WDATA, CFG_BE,
      swpc_pkg::LTR_MASK);
    sel_merged = be_merge({24'h00_0000, st_ff.pb_sel}, CFG_WDATA,
      CFG_BE, 32'h0000_00FF);
    // every request seen with CE high is answered one edge later, read or write
    nxt_st.ack = CFG_REQ;
    nxt_st.rdata = (CFG_REQ && !CFG_WR) ? rd_word : '0;
    if (wr_hit)
    begin
      case (CFG_ADDR & 12'hFFC)
        swpc_pkg::OFS_CMD:
        begin
          nxt_st.io_en = cmd_merged[swpc_pkg::CMD_IO]; // RQ1
          nxt_st.mem_en = cmd_merged[swpc_pkg::CMD_MEM]; // RQ2
          nxt_st.bm_en = cmd_merged[swpc_pkg::CMD_BM]; // RQ3 RQ5
          nxt_st.perr_en = cmd_merged[swpc_pkg::CMD_PERR]; // RQ7
          nxt_st.serr_en = cmd_merged[swpc_pkg::CMD_SERR]; // RQ8
          nxt_st.intx_dis = cmd_merged[swpc_pkg::CMD_INTD]; // RQ9
          nxt_st.rsvd = cmd_merged[swpc_pkg::CMD_RSVD_MSB:
            swpc_pkg::CMD_RSVD_LSB]; // RQ12
        end
        swpc_pkg::OFS_PB_SEL:
          nxt_st.pb_sel = sel_merged[7:0];
        swpc_pkg::OFS_ACS_CC:
          nxt_st.acs_ctl = acs_merged[31:swpc_pkg::ACS_CTL_LSB]; // RQ11
        swpc_pkg::OFS_EGRESS:
          nxt_st.egress = egr_merged[swpc_pkg::EGRESS_W-1:0]; // RQ11
        swpc_pkg::OFS_LTR_SNOOP:
          nxt_st.ltr = ltr_merged;
        default:
          nxt_st.ltr = st_ff.ltr;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************

  // all command bits clear at reset, so decoding starts disabled
  always_ff @(posedge CLK)
  begin
    if (SRST)
      st_ff <= '0; // RQ1 RQ2 RQ7 RQ8 RQ9
    else if (CE)
      st_ff <= nxt_st;
  end

  // ****************************************
  // outputs
  // ****************************************

  // control bundle to the filter
  assign ctl.io_en = st_ff.io_en;
  assign ctl.mem_en = st_ff.mem_en;
  assign ctl.bm_en = st_ff.bm_en;
  assign ctl.perr_en = st_ff.perr_en;
  assign ctl.serr_en = st_ff.serr_en;
  assign ctl.intx_dis = st_ff.intx_dis;

  // bus answer straight from flops
  assign CFG_RDATA = st_ff.rdata;
  assign CFG_ACK = st_ff.ack;

  // filter pulses, registered inside the filter
  assign PRI_REQ_TAKE = flt_q.pri_take;
  assign PRI_REQ_IGNORE = flt_q.pri_ign;
  assign DN_REQ_FWD = flt_q.dn_fwd;
  assign DN_REQ_UR = flt_q.dn_ur;
  assign DN_UR_CPL = flt_q.dn_cpl;
  assign OWN_REQ_GO = flt_q.own_go;
  assign PERR_ACT = flt_q.perr_act;
  assign ERR_MSG = flt_q.err_msg;
  assign OWN_INTX_MSG = flt_q.intx_msg;
  assign DN_INTX_FWD = flt_q.intx_fwd;

  // capability controls that steer the fabric
  assign ACS_CTRL = st_ff.acs_ctl;
  assign EGRESS_BLOCK = st_ff.egress;
  assign LTR_SNOOP = st_ff.ltr;

endmodule : swpc_config_top
`default_nettype wire

// ==== logic/swpc_ctl_if.sv ====
/*
  Control bundle between the register bank, id loader and request filter.
  Assumes all three sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface swpc_ctl_if;
  logic [15:0] vendor_identifier;
  logic [15:0] device_identifier;
  logic io_en;
  logic mem_en;
  logic bm_en;
  logic perr_en;
  logic serr_en;
  logic intx_dis;
  modport regs (input vendor_identifier, device_identifier,
    output io_en, mem_en, bm_en, perr_en, serr_en, intx_dis);
  modport idl (output vendor_identifier, device_identifier);
  modport flt (input io_en, mem_en, bm_en, perr_en, serr_en, intx_dis);
endinterface : swpc_ctl_if
`default_nettype wire

// ==== logic/swpc_id_loader.sv ====
/*
  Holds the vendor and device identifiers and their override path.
  Assumes override strobes come from same-clock SMBus and EEPROM logic.
*/
`timescale 1ns/1ns
`default_nettype none
module swpc_id_loader (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic smb_we,
  input wire logic smb_sel,
  input wire logic [15:0] smb_data,
  input wire logic ee_we,
  input wire logic ee_sel,
  input wire logic [15:0] ee_data,
  swpc_ctl_if.idl ctl
);
  swpc_pkg::swpc_id_st_t st_ff;
  swpc_pkg::swpc_id_st_t nxt_st;

  // smbus wins a same-cycle collision: it is the later, manual source
  always_comb
  begin
    nxt_st = st_ff;
    if (ee_we)
    begin
      if (ee_sel) nxt_st.device = ee_data; // RQ10
      else nxt_st.vendor = ee_data; // RQ10
    end
    if (smb_we)
    begin
      if (smb_sel) nxt_st.device = smb_data; // RQ10
      else nxt_st.vendor = smb_data; // RQ10
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff.vendor <= swpc_pkg::VENDOR_DEF;
      st_ff.device <= swpc_pkg::DEVICE_DEF;
    end
    else if (ce) st_ff <= nxt_st;
  end

  assign ctl.vendor_identifier = st_ff.vendor;
  assign ctl.device_identifier = st_ff.device;
endmodule : swpc_id_loader
`default_nettype wire

// ==== logic/swpc_pkg.sv ====
/*
  Constants and types shared by the switch port configuration block.
  Assumes byte offsets of twelve bits and dword-wide configuration data.
*/
`default_nettype none
package swpc_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_ID = 12'h000;
  localparam logic [11:0] OFS_CMD = 12'h004;
  localparam logic [11:0] OFS_PB_SEL = 12'h210;
  localparam logic [11:0] OFS_PB_DATA = 12'h214;
  localparam logic [11:0] OFS_PB_CAP = 12'h218;
  localparam logic [11:0] OFS_ACS_HDR = 12'h220;
  localparam logic [11:0] OFS_ACS_CC = 12'h224;
  localparam logic [11:0] OFS_EGRESS = 12'h228;
  localparam logic [11:0] OFS_LTR_HDR = 12'h230;
  localparam logic [11:0] OFS_LTR_SNOOP = 12'h234;
  // ****************************************
  // command field positions
  // ****************************************
  localparam int unsigned CMD_IO = 0;
  localparam int unsigned CMD_MEM = 1;
  localparam int unsigned CMD_BM = 2;
  localparam int unsigned CMD_PERR = 6;
  localparam int unsigned CMD_SERR = 8;
  localparam int unsigned CMD_INTD = 10;
  localparam int unsigned CMD_RSVD_LSB = 11;
  localparam int unsigned CMD_RSVD_MSB = 15;
  localparam int unsigned ID_DEV_LSB = 16;
  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam logic [15:0] VENDOR_DEF = 16'h1A2B; // arbitrary value
  localparam logic [15:0] DEVICE_DEF = 16'h3C4D; // arbitrary value
  localparam logic [11:0] NEXT_NONE = 12'h000;
  localparam logic [3:0] CAP_VER = 4'h1;
  localparam logic [15:0] ACS_CAP_ID = 16'h000D;
  localparam logic [15:0] LTR_CAP_ID = 16'h0018;
  localparam logic [15:0] ACS_CAP_VAL = 16'h001F;
  localparam logic [15:0] ACS_CTL_MASK = 16'h007F;
  localparam int unsigned ACS_CTL_LSB = 16;
  localparam int unsigned EGRESS_W = 8;
  localparam logic [31:0] LTR_MASK = 32'h1FFF_1FFF;
  localparam logic [7:0] PB_CAP_VAL = 8'h01;
  localparam int unsigned PB_ENTRIES = 4;
  localparam logic [3:0][31:0] PB_TABLE = {32'h0000_0000,
    32'h0000_0000, 32'h0000_8319, 32'h0000_831E};
  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] device;
  } swpc_id_st_t;
  typedef struct packed {
    logic pri_take;
    logic pri_ign;
    logic dn_fwd;
    logic dn_ur;
    logic dn_cpl;
    logic own_go;
    logic perr_act;
    logic err_msg;
    logic intx_msg;
    logic intx_fwd;
  } swpc_flt_st_t;
  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic bm_en;
    logic perr_en;
    logic serr_en;
    logic intx_dis;
    logic [4:0] rsvd;
    logic [7:0] pb_sel;
    logic [15:0] acs_ctl;
    logic [7:0] egress;
    logic [31:0] ltr;
    logic [31:0] rdata;
    logic ack;
  } swpc_top_st_t;
endpackage : swpc_pkg
`default_nettype wire

// ==== logic/swpc_req_filter.sv ====
/*
  Gates request decoding, forwarding and messages by the command bits.
  Assumes request strobes are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module swpc_req_filter (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  swpc_ctl_if.flt ctl,
  input wire logic pri_valid,
  input wire logic pri_io,
  input wire logic dn_valid,
  input wire logic dn_np,
  input wire logic own_valid,
  input wire logic perr_det,
  input wire logic err_det,
  input wire logic own_intx,
  input wire logic dn_intx,
  output var swpc_pkg::swpc_flt_st_t q
);
  swpc_pkg::swpc_flt_st_t st_ff;
  swpc_pkg::swpc_flt_st_t nxt_st;
  logic pri_en;

  // each answer is registered one edge after its request while CE is high, and held while CE is low
  always_comb
  begin
    pri_en = pri_io ? ctl.io_en : ctl.mem_en; // RQ1 RQ2
    nxt_st.pri_take = pri_valid && pri_en; // RQ1 RQ2
    nxt_st.pri_ign = pri_valid && !pri_en; // RQ1 RQ2
    nxt_st.dn_fwd = dn_valid && ctl.bm_en; // RQ5
    nxt_st.dn_ur = dn_valid && !ctl.bm_en; // RQ3
    nxt_st.dn_cpl = dn_valid && dn_np && !ctl.bm_en; // RQ4
    nxt_st.own_go = own_valid && ctl.bm_en; // RQ3
    nxt_st.perr_act = perr_det && ctl.perr_en; // RQ7
    nxt_st.err_msg = err_det && ctl.serr_en; // RQ8
    nxt_st.intx_msg = own_intx && !ctl.intx_dis; // RQ9
    // forwarded interrupts ignore the disable bit on purpose
    nxt_st.intx_fwd = dn_intx; // RQ9
  end

  always_ff @(posedge clk)
  begin
    if (srst) st_ff <= '0;
    else if (ce) st_ff <= nxt_st;
  end

  assign q = st_ff;
endmodule : swpc_req_filter
`default_nettype wire

// ==== test/swpc_chk.sv ====
/*
  Port assertions for the switch port configuration block.
  Assumes it is bound to swpc_config_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module swpc_chk (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic CFG_REQ,
  input wire logic CFG_WR,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic PRI_REQ_VALID,
  input wire logic PRI_REQ_IO,
  input wire logic PRI_REQ_TAKE,
  input wire logic DN_REQ_VALID,
  input wire logic DN_REQ_NP,
  input wire logic DN_REQ_FWD,
  input wire logic DN_REQ_UR,
  input wire logic DN_UR_CPL,
  input wire logic PERR_DET,
  input wire logic PERR_ACT,
  input wire logic ERR_DET,
  input wire logic ERR_MSG,
  input wire logic OWN_INTX,
  input wire logic OWN_INTX_MSG,
  input wire logic [15:0] ACS_CTRL
);
  // ****************************************
  // shadow of the writable command bits
  // ****************************************
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  // only bits 0,1,2,6,8,10 read back what was written, so the mask is fixed here
  always_comb
  begin
    nxt_cmd = cmd_ff;
    if (CFG_REQ && CFG_WR && CFG_ADDR[11:2] == 10'h001)
    begin
      if (CFG_BE[0]) nxt_cmd[7:0] = CFG_WDATA[7:0] & 8'h47;
      if (CFG_BE[1]) nxt_cmd[15:8] = CFG_WDATA[15:8] & 8'h05;
    end
  end
  // reset wins over a frozen clock enable
  always_ff @(posedge CLK)
    if (SRST) cmd_ff <= 16'h0000;
    else if (CE) cmd_ff <= nxt_cmd;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // an event sees the command value in force at its own edge
  property gate(logic v, logic o, logic b);
    CE && v |=> o == $past(b);
  endproperty
  a_io_gate: assert property (
    CE && PRI_REQ_VALID && PRI_REQ_IO |=> PRI_REQ_TAKE == $past(cmd_ff[0]))
    else $error("io request gating wrong");
  a_mem_gate: assert property (
    CE && PRI_REQ_VALID && !PRI_REQ_IO |=> PRI_REQ_TAKE == $past(cmd_ff[1]))
    else $error("memory request gating wrong");
  a_dn_unsup: assert property (
    CE && DN_REQ_VALID |=> DN_REQ_UR != $past(cmd_ff[2]))
    else $error("downstream unsupported flag wrong");
  a_ur_cpl: assert property (
    CE && DN_REQ_VALID && DN_REQ_NP |=> DN_UR_CPL != $past(cmd_ff[2]))
    else $error("unsupported completion wrong");
  a_up_fwd: assert property (gate(DN_REQ_VALID, DN_REQ_FWD, cmd_ff[2]))
    else $error("upstream forwarding wrong");
  a_cmd_read: assert property (
    CE && CFG_REQ && !CFG_WR && CFG_ADDR[11:2] == 10'h001
    |=> CFG_RDATA == {16'h0000, $past(cmd_ff)})
    else $error("command readback wrong");
  a_perr_act: assert property (gate(PERR_DET, PERR_ACT, cmd_ff[6]))
    else $error("parity action wrong");
  a_err_msg: assert property (gate(ERR_DET, ERR_MSG, cmd_ff[8]))
    else $error("error report wrong");
  a_intx_own: assert property (
    CE && OWN_INTX |=> OWN_INTX_MSG != $past(cmd_ff[10]))
    else $error("own interrupt message wrong");
  a_acs_place: assert property (
    CE && CFG_REQ && !CFG_WR && CFG_ADDR[11:2] == 10'h089
    |=> CFG_RDATA == {$past(ACS_CTRL), 16'h001F})
    else $error("access control dword wrong");
  c_ur_cpl: cover property (DN_UR_CPL);
  c_intx_block: cover property (CE && OWN_INTX ##1 !OWN_INTX_MSG);
  c_take: cover property (PRI_REQ_TAKE);
endmodule : swpc_chk
bind swpc_config_top swpc_chk u_chk (.CLK(CLK), .SRST(SRST), .CE(CE),
  .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
  .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
  .PRI_REQ_VALID(PRI_REQ_VALID), .PRI_REQ_IO(PRI_REQ_IO),
  .PRI_REQ_TAKE(PRI_REQ_TAKE), .DN_REQ_VALID(DN_REQ_VALID),
  .DN_REQ_NP(DN_REQ_NP), .DN_REQ_FWD(DN_REQ_FWD), .DN_REQ_UR(DN_REQ_UR),
  .DN_UR_CPL(DN_UR_CPL), .PERR_DET(PERR_DET), .PERR_ACT(PERR_ACT),
  .ERR_DET(ERR_DET), .ERR_MSG(ERR_MSG), .OWN_INTX(OWN_INTX),
  .OWN_INTX_MSG(OWN_INTX_MSG), .ACS_CTRL(ACS_CTRL));
`default_nettype wire

// ==== test/swpc_rc_model.sv ====
/*
  Root complex model issuing configuration requests, one per call.
  Assumes the bench calls drive once at every rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module swpc_rc_model (
  input wire logic CLK,
  output logic CFG_REQ,
  output logic CFG_WR,
  output logic [11:0] CFG_ADDR,
  output logic [3:0] CFG_BE,
  output logic [31:0] CFG_WDATA
);
  // ****************************************
  // request lanes
  // ****************************************
  // quiet bus at time zero
  initial
  begin
    CFG_REQ = 1'b0;
    CFG_WR = 1'b0;
    CFG_ADDR = 12'h000;
    CFG_BE = 4'h0;
    CFG_WDATA = 32'h0;
  end
  // idle lanes flip so a stale address or data never looks valid
  task automatic drive(input logic rq, wr, input logic [11:0] a,
    input logic [3:0] be, input logic [31:0] w);
    CFG_REQ <= rq;
    CFG_WR <= rq ? wr : ~CFG_WR;
    CFG_ADDR <= rq ? a : ~CFG_ADDR;
    CFG_BE <= rq ? be : ~CFG_BE;
    CFG_WDATA <= rq ? w : ~CFG_WDATA;
  endtask : drive
endmodule : swpc_rc_model
`default_nettype wire

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the switch port configuration block.
  Assumes the root complex model and the checker bound to the design.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_top;
  typedef struct {
    int t;
    logic [42:0] v;
  } swpc_note_t;
  localparam int LIMIT = 2000;
  localparam logic [2:0] RD = 3'h6;
  localparam logic [2:0] WR = 3'h7;
  logic CLK, SRST, CE, SMB_ID_WE, SMB_ID_SEL, EE_ID_WE, EE_ID_SEL;
  logic [15:0] SMB_ID_DATA, EE_ID_DATA, cmd, vid, did, acs;
  logic [8:0] ev;
  logic [7:0] sel, egr;
  logic [31:0] ltr, t;
  logic [42:0] last;
  wire CFG_REQ, CFG_WR, CFG_ACK;
  wire [11:0] CFG_ADDR;
  wire [3:0] CFG_BE;
  wire [31:0] CFG_WDATA, CFG_RDATA, LTR_SNOOP;
  wire [15:0] ACS_CTRL;
  wire [7:0] EGRESS_BLOCK;
  wire [9:0] fo;
  int cyc = 0;
  int miscompares = 0;
  int check_count = 0;
  int seed;
  swpc_note_t notes[$];
  swpc_note_t cur;
  logic [11:0] amap [13] = '{12'h000, 12'h004, 12'h100, 12'h210, 12'h214,
    12'h218, 12'h21C, 12'h220, 12'h224, 12'h228, 12'h22C, 12'h230, 12'h234};
  // ****************************************
  // design and partner
  // ****************************************
  swpc_config_top uut (.CLK(CLK), .SRST(SRST), .CE(CE), .CFG_REQ(CFG_REQ),
    .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_ACK(CFG_ACK),
    .SMB_ID_WE(SMB_ID_WE), .SMB_ID_SEL(SMB_ID_SEL),
    .SMB_ID_DATA(SMB_ID_DATA), .EE_ID_WE(EE_ID_WE), .EE_ID_SEL(EE_ID_SEL),
    .EE_ID_DATA(EE_ID_DATA), .PRI_REQ_VALID(ev[8]), .PRI_REQ_IO(ev[7]),
    .PRI_REQ_TAKE(fo[9]), .PRI_REQ_IGNORE(fo[8]), .DN_REQ_VALID(ev[6]),
    .DN_REQ_NP(ev[5]), .DN_REQ_FWD(fo[7]), .DN_REQ_UR(fo[6]),
    .DN_UR_CPL(fo[5]), .OWN_REQ_VALID(ev[4]), .OWN_REQ_GO(fo[4]),
    .PERR_DET(ev[3]), .PERR_ACT(fo[3]), .ERR_DET(ev[2]), .ERR_MSG(fo[2]),
    .OWN_INTX(ev[1]), .OWN_INTX_MSG(fo[1]), .DN_INTX(ev[0]),
    .DN_INTX_FWD(fo[0]), .ACS_CTRL(ACS_CTRL), .EGRESS_BLOCK(EGRESS_BLOCK),
    .LTR_SNOOP(LTR_SNOOP));
  swpc_rc_model rc (.CLK(CLK), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR),
    .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA));
  // ****************************************
  // expected behaviour
  // ****************************************
  function automatic logic [31:0] rexp(input logic [11:0] a);
    case (a[11:2])
      10'h000: return {did, vid};
      10'h001: return {16'h0000, cmd};
      10'h084: return {24'h0, sel};
      10'h085: return sel < 8'h04 ? swpc_pkg::PB_TABLE[sel[1:0]] : 32'h0;
      10'h086: return {24'h0, swpc_pkg::PB_CAP_VAL};
      10'h088: return {swpc_pkg::NEXT_NONE, swpc_pkg::CAP_VER, 16'h000D};
      10'h089: return {acs, swpc_pkg::ACS_CAP_VAL};
      10'h08A: return {24'h0, egr};
      10'h08C: return {swpc_pkg::NEXT_NONE, swpc_pkg::CAP_VER, 16'h0018};
      10'h08D: return ltr;
      default: return 32'h0;
    endcase
  endfunction : rexp
  // byte lanes merge, then each place keeps only its writable bits
  task automatic wupd(input logic [11:0] a, input logic [3:0] be,
    input logic [31:0] w);
    t = rexp(a);
    for (int i = 0; i < 4; i++)
      if (be[i]) t[8*i +: 8] = w[8*i +: 8];
    case (a[11:2])
      10'h001: cmd = t[15:0] & 16'h0547;
      10'h084: sel = t[7:0];
      10'h089: acs = t[31:16] & 16'h007F;
      10'h08A: egr = t[7:0];
      10'h08D: ltr = t & swpc_pkg::LTR_MASK;
      default: ;
    endcase
  endtask : wupd
  function automatic logic [9:0] fexp(input logic [8:0] e);
    logic hit;
    hit = e[7] ? cmd[0] : cmd[1];
    return {e[8] && hit, e[8] && !hit, e[6] && cmd[2], e[6] && !cmd[2],
      e[6] && e[5] && !cmd[2], e[4] && cmd[2], e[3] && cmd[6],
      e[2] && cmd[8], e[1] && !cmd[10], e[0]};
  endfunction : fexp
  // one cycle of stimulus; a frozen cycle expects the outputs to hold
  task automatic step(input logic [2:0] m, input logic [11:0] a,
    input logic [3:0] be = 4'h0, input logic [31:0] w = 32'h0,
    input logic [8:0] e = 9'h000);
    swpc_note_t n;
    n.t = cyc + 2;
    n.v = last;
    if (m[2])
    begin
      n.v = {m[1], (m[1] && !m[0]) ? rexp(a) : 32'h0, fexp(e)};
      if (m[1] && m[0]) wupd(a, be, w);
    end
    last = n.v;
    notes.push_back(n);
    CE <= m[2];
    ev <= e;
    rc.drive(m[1], m[0], a, be, w);
    @(posedge CLK);
  endtask : step
  // identifier override; the second source applied wins a tie
  task automatic idov(input logic sw, ss, ew, es, input logic [15:0] sd, ed);
    SMB_ID_WE <= sw;
    SMB_ID_SEL <= ss;
    SMB_ID_DATA <= sd;
    EE_ID_WE <= ew;
    EE_ID_SEL <= es;
    EE_ID_DATA <= ed;
    if (ew && es) did = ed;
    if (ew && !es) vid = ed;
    if (sw && ss) did = sd;
    if (sw && !ss) vid = sd;
    step(3'h4, 12'h000);
  endtask : idov
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // ****************************************
  // clock, watchdog and monitor
  // ****************************************
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // cycle count doubles as the hang limit
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      complete_run();
    end
  end
  // compare the oldest note in the cycle its result is due
  always @(negedge CLK)
    if (notes.size() > 0 && notes[0].t == cyc)
    begin
      cur = notes.pop_front();
      `CHK("cfg", cur.v[42:10], {CFG_ACK, CFG_RDATA})
      `CHK("primary", cur.v[9:8], fo[9:8])
      `CHK("upstream", cur.v[7:4], fo[7:4])
      `CHK("messages", cur.v[3:0], fo[3:0])
    end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 32'hA525;
    {SRST, CE, ev, last} = {1'b1, 1'b1, 9'h000, 43'h0};
    {SMB_ID_WE, SMB_ID_SEL, SMB_ID_DATA} = 18'h0;
    {EE_ID_WE, EE_ID_SEL, EE_ID_DATA} = 18'h0;
    {cmd, acs, sel, egr, ltr} = 80'h0;
    vid = swpc_pkg::VENDOR_DEF;
    did = swpc_pkg::DEVICE_DEF;
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    // reset values, then each place written and read back to back
    foreach (amap[i]) step(RD, amap[i]);
    foreach (amap[i])
    begin
      step(WR, amap[i], 4'hF, $random(seed));
      step(RD, amap[i]);
    end
    step(WR, 12'h210, 4'h1, 32'h0000_0001);
    step(RD, 12'h214);
    idov(1'b1, 1'b0, 1'b0, 1'b0, 16'($random(seed)), 16'h0000);
    idov(1'b0, 1'b0, 1'b1, 1'b1, 16'h0000, 16'($random(seed)));
    idov(1'b1, 1'b1, 1'b1, 1'b1, 16'($random(seed)), 16'($random(seed)));
    idov(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
    step(RD, 12'h000);
    // events share the edge of a command write, then random freezes
    repeat (40)
    begin
      step(WR, 12'h004, 4'($random(seed)), $random(seed), 9'($random(seed)));
      step({($random(seed) & 3) != 0, 2'h2}, 12'h004, 4'h0, 32'h0,
        9'($random(seed)));
    end
    step(3'h4, 12'h000);
    repeat (2) @(negedge CLK);
    `CHK("lvl", {acs, egr, ltr}, {ACS_CTRL, EGRESS_BLOCK, LTR_SNOOP})
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
